/* rtl/sfe_pkg.sv */
// Summary of operation
// - Sector erase clears 4K sector, A12 up
// - Half block erase clears 32K, A15 up
// - Block erase clears 64K containing address
// - Chip erase clears all but locked blocks, no address
// - Host sends write enable before erase
// - Host frames opcode, 3/4 address bytes
// - Addressed erase: chip select after last bit
// - Chip erase: chip select after opcode byte
// - Three byte default; four byte or extended
// - Opcode 8 serial or 2 quad clocks
// - Erase cycle starts at chip select rise
// - Busy during cycle; end clears busy, latch
// - Busy flag readable during erase cycle
// - Protected sector or block not erased
// - Block protect mode: chip erase needs zero
// - Advanced mode: chip erase skips locked blocks
// - Chip erase frame is opcode only
package sfe_pkg;
  localparam logic [7:0] WRITE_ENABLE_CMD            = 8'h06;
  localparam logic [7:0] READ_STATUS_CMD             = 8'h05;
  localparam logic [7:0] SECTOR_ERASE_CMD            = 8'h20;
  localparam logic [7:0] HALF_BLOCK_ERASE_CMD        = 8'h52;
  localparam logic [7:0] BLOCK_ERASE_CMD             = 8'hD8;
  localparam logic [7:0] CHIP_ERASE_CMD              = 8'h60;
  localparam logic [7:0] FOUR_BYTE_MODE_ENTRY_CMD    = 8'hB7;
  localparam logic [7:0] FOUR_BYTE_MODE_EXIT_CMD     = 8'hE9;
  localparam logic [6:0] LEN_OP                      = 7'd8;
  localparam logic [6:0] LEN_A3                      = 7'd32;
  localparam logic [6:0] LEN_A4                      = 7'd40;
  localparam int         BLOCK_LSB                   = 16;
  localparam logic [31:0] SECTOR_MASK                = 32'hFFFFF000;
  localparam logic [31:0] HALF_MASK                  = 32'hFFFF8000;
  localparam logic [31:0] BLOCK_MASK                 = 32'hFFFF0000;
  localparam int         ST_BUSY_BIT                 = 0;
  localparam int         ST_WEL_BIT                  = 1;
  localparam logic [7:0] REG_CMD                     = 8'h00;
  localparam logic [7:0] REG_ADDR                    = 8'h04;
  localparam logic [7:0] REG_STAT                    = 8'h08;
  localparam logic [7:0] REG_RXD                     = 8'h0C;
  localparam logic [7:0] REG_ISTAT                   = 8'h10;
  localparam logic [7:0] REG_IMASK                   = 8'h14;
  localparam int         CMD_NADR_LSB                = 8;
  localparam int         CMD_QUAD_BIT                = 11;
  localparam int         CMD_RD_BIT                  = 12;
  localparam int         EV_DONE_BIT                 = 0;
  localparam int         EV_REFUSED_BIT              = 1;
  localparam logic [1:0] RESP_OKAY                   = 2'h0;
  localparam logic [1:0] RESP_SLVERR                 = 2'h2;
  typedef enum logic [1:0] {
    KIND_SECTOR = 2'h0,
    KIND_HALF   = 2'h1,
    KIND_BLOCK  = 2'h3,
    KIND_CHIP   = 2'h2
  } sfe_kind_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_CSL  = 2'h1,
    H_XFER = 2'h3,
    H_END  = 2'h2
  } sfe_hstate_t;
endpackage : sfe_pkg

/* rtl/sfe_link_if.sv */
`timescale 1ns/1ns
interface sfe_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] h_sio_o;
  logic [3:0] h_sio_oe;
  logic [3:0] d_sio_o;
  logic [3:0] d_sio_oe;
  logic [3:0] sio;
  // Undriven lines read low instead of floating
  assign sio = (d_sio_oe & d_sio_o) | (h_sio_oe & ~d_sio_oe & h_sio_o);
  modport host (output cs_n, output sclk, output h_sio_o, output h_sio_oe, input sio);
  modport flash (input cs_n, input sclk, input sio, output d_sio_o, output d_sio_oe);
endinterface : sfe_link_if

/* rtl/sfe_host_end.sv */
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
module sfe_host_end
  import sfe_pkg::*;
#(
  parameter int DIV = 2
) (
  sfe_link_if.host    LINK,
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             IRQ
);
  sfe_hstate_t st_r;
  logic        aw_got_r, w_got_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r, addr_r;
  logic [7:0]  op_r;
  logic [2:0]  nadr_r;
  logic        quad_r, rd_r;
  logic [39:0] tx_r;
  logic [7:0]  rx_r, rxd_r;
  logic [7:0]  ph_r, clks_r;
  logic        sclk_r, cs_n_r, rdph_r;
  logic [1:0]  istat_r, imask_r;

  wire do_wr    = aw_got_r & w_got_r & ~S_AXI_BVALID;
  wire wr_cmd   = do_wr & (awaddr_r == REG_CMD);
  wire wr_addr  = do_wr & (awaddr_r == REG_ADDR);
  wire wr_mask  = do_wr & (awaddr_r == REG_IMASK);
  wire wr_hit   = wr_cmd | wr_addr | wr_mask;
  wire rd_take  = S_AXI_ARVALID & S_AXI_ARREADY;
  wire rd_istat = rd_take & (S_AXI_ARADDR == REG_ISTAT);
  wire rd_hit   = (S_AXI_ARADDR == REG_CMD) | (S_AXI_ARADDR == REG_ADDR) | (S_AXI_ARADDR == REG_STAT) |
                  (S_AXI_ARADDR == REG_RXD) | (S_AXI_ARADDR == REG_ISTAT) | (S_AXI_ARADDR == REG_IMASK);
  wire [31:0] rd_val = (S_AXI_ARADDR == REG_CMD)   ? {19'h0, rd_r, quad_r, nadr_r, op_r} :
                       (S_AXI_ARADDR == REG_ADDR)  ? addr_r :
                       (S_AXI_ARADDR == REG_STAT)  ? {31'h0, st_r != H_IDLE} :
                       (S_AXI_ARADDR == REG_RXD)   ? {24'h0, rxd_r} :
                       (S_AXI_ARADDR == REG_ISTAT) ? {30'h0, istat_r} :
                       (S_AXI_ARADDR == REG_IMASK) ? {30'h0, imask_r} : 32'h0;
  wire        start    = wr_cmd & (st_r == H_IDLE);
  wire [2:0]  nadr_w   = (wdata_r[CMD_NADR_LSB +: 3] > 3'h4) ? 3'h4 : wdata_r[CMD_NADR_LSB +: 3];
  wire [7:0]  wbits    = 8'h08 + {2'h0, nadr_r, 3'h0};
  wire [7:0]  wclks    = quad_r ? {2'h0, wbits[7:2]} : wbits;
  wire [7:0]  nclks    = wclks + (rd_r ? (quad_r ? 8'h02 : 8'h08) : 8'h00);
  wire        ph_end   = (ph_r == 8'(DIV - 1));
  wire        ev_done  = (st_r == H_END) & ph_end;
  wire [1:0]  ev_set   = {wr_cmd & ~start, ev_done};
  wire [31:0] addr_sh  = addr_r << {(3'h4 - nadr_r), 3'h0};

  assign S_AXI_AWREADY = ~aw_got_r & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = ~w_got_r & ~S_AXI_BVALID;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  assign IRQ           = |(istat_r & imask_r);
  assign LINK.cs_n     = cs_n_r;
  assign LINK.sclk     = sclk_r;
  assign LINK.h_sio_o  = quad_r ? tx_r[39:36] : {3'h0, tx_r[39]};
  // Release the lines at the clock fall after the last write clock; device drive wins any overlap
  assign LINK.h_sio_oe = (cs_n_r | rdph_r) ? 4'h0 : (quad_r ? 4'hF : 4'h1);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP  <= RESP_OKAY;
      S_AXI_RDATA  <= 32'h0;
    end else begin
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_got_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_got_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
      end
      if (do_wr) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (rd_take) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_val;
        S_AXI_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Set wins over the read-to-clear
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      istat_r <= 2'h0;
      imask_r <= 2'h0;
      addr_r  <= 32'h0;
    end else begin
      istat_r <= (rd_istat ? 2'h0 : istat_r) | ev_set;
      if (wr_mask) imask_r <= wdata_r[1:0];
      if (wr_addr && S_AXI_WSTRB == 4'hF) addr_r <= wdata_r;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r   <= H_IDLE;
      op_r   <= 8'h00;
      nadr_r <= 3'h0;
      quad_r <= 1'b0;
      rd_r   <= 1'b0;
      tx_r   <= 40'h0;
      rx_r   <= 8'h00;
      rxd_r  <= 8'h00;
      ph_r   <= 8'h00;
      clks_r <= 8'h00;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      rdph_r <= 1'b0;
    end else begin
      ph_r <= (ph_end || st_r == H_IDLE) ? 8'h00 : ph_r + 8'h01;
      case (st_r)
        H_IDLE: begin
          if (start) begin
            op_r   <= wdata_r[7:0];
            nadr_r <= nadr_w;
            quad_r <= wdata_r[CMD_QUAD_BIT];
            rd_r   <= wdata_r[CMD_RD_BIT];
            st_r   <= H_CSL;
          end
        end
        H_CSL: begin
          cs_n_r <= 1'b0;
          tx_r   <= {op_r, addr_sh};
          clks_r <= 8'h00;
          rdph_r <= 1'b0;
          if (ph_end) st_r <= H_XFER;
        end
        H_XFER: begin
          if (ph_end && !sclk_r) begin
            sclk_r <= 1'b1;
            clks_r <= clks_r + 8'h01;
            if (clks_r >= wclks) rx_r <= quad_r ? {rx_r[3:0], LINK.sio} : {rx_r[6:0], LINK.sio[1]};
          end else if (ph_end) begin
            sclk_r <= 1'b0;
            tx_r   <= quad_r ? {tx_r[35:0], 4'h0} : {tx_r[38:0], 1'b0};
            if (clks_r == wclks) rdph_r <= 1'b1;
            if (clks_r == nclks) st_r <= H_END;
          end
        end
        H_END: begin
          if (ph_end) begin
            cs_n_r <= 1'b1;
            rxd_r  <= rx_r;
            st_r   <= H_IDLE;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end
endmodule : sfe_host_end

/* rtl/sfe_flash_end.sv */
`timescale 1ns/1ns
module sfe_flash_end
  import sfe_pkg::*;
#(
  parameter int NBLK     = 16,
  parameter int SE_CYC   = 5000,
  parameter int HBE_CYC  = 10000,
  parameter int BE_CYC   = 20000,
  parameter int CE_CYC   = 80000
) (
  sfe_link_if.flash        LINK,
  input  wire logic            CLK,
  input  wire logic            RESET_N,
  input  wire logic            PROTECTION_SCHEME_SELECT,
  input  wire logic [3:0]      BLOCK_PROTECT_BITS,
  input  wire logic [NBLK-1:0] PERSISTENT_SECTOR_LOCK,
  input  wire logic [NBLK-1:0] DYNAMIC_SECTOR_LOCK,
  input  wire logic            QUAD_COMMAND_MODE,
  input  wire logic            EXTENDED_ADDRESS_BIT,
  output logic                 ERASE_GO,
  output sfe_kind_t            ERASE_KIND,
  output logic [31:0]          ERASE_BASE,
  output logic [NBLK-1:0]      ERASE_SKIP,
  output logic                 ERASE_DONE,
  output logic                 BUSY_FLAG,
  output logic                 WRITE_ENABLE_LATCH,
  output logic                 FOUR_BYTE_MODE
);
  localparam int BW = $clog2(NBLK);

  logic        sclk_q_r;
  logic        cs_q_r;
  logic [6:0]  cnt_r;
  logic [7:0]  op_r;
  logic [31:0] addr_r;
  logic        busy_r;
  logic        wel_r;
  logic        addr4_r;
  logic [31:0] tmr_r;
  logic [3:0]  dout_r;

  wire sclk_rise = LINK.sclk & ~sclk_q_r;
  wire sclk_fall = ~LINK.sclk & sclk_q_r;
  wire cs_rise   = LINK.cs_n & ~cs_q_r;
  wire sel       = ~LINK.cs_n;

  // Serial mode looks at line 0 only, the upper data lines are don't care
  wire [6:0] step     = QUAD_COMMAND_MODE ? 7'd4 : 7'd1;
  wire [6:0] cnt_nxt  = (cnt_r > 7'd120) ? cnt_r : cnt_r + step;
  wire [7:0] op_nxt   = QUAD_COMMAND_MODE ? {op_r[3:0], LINK.sio} : {op_r[6:0], LINK.sio[0]};
  wire [31:0] addr_nxt = QUAD_COMMAND_MODE ? {addr_r[27:0], LINK.sio} : {addr_r[30:0], LINK.sio[0]};

  wire [31:0] addr_full = addr4_r ? addr_r : {7'h00, EXTENDED_ADDRESS_BIT, addr_r[23:0]};
  wire [6:0]  need      = addr4_r ? LEN_A4 : LEN_A3;

  wire is_sector = (op_r == SECTOR_ERASE_CMD);
  wire is_half   = (op_r == HALF_BLOCK_ERASE_CMD);
  wire is_block  = (op_r == BLOCK_ERASE_CMD);
  wire is_chip   = (op_r == CHIP_ERASE_CMD);
  wire is_addr   = is_sector | is_half | is_block;
  wire op_only   = (cnt_r == LEN_OP);

  // Block protect covers the top 2^(n-1) blocks, the whole array once that reaches NBLK
  wire [BW-1:0]   blk      = addr_full[BLOCK_LSB +: BW];
  wire [31:0]     bp_m1    = {28'h0, BLOCK_PROTECT_BITS} - 32'h1;
  wire [31:0]     bp_cnt   = (BLOCK_PROTECT_BITS == 4'h0) ? 32'h0 :
                             ((bp_m1 >= 32'(BW)) ? 32'(NBLK) : (32'h1 << bp_m1));
  wire            bp_hit   = (32'(blk) + bp_cnt) >= 32'(NBLK);
  wire [NBLK-1:0] locks    = PERSISTENT_SECTOR_LOCK | DYNAMIC_SECTOR_LOCK;
  wire            prot_hit = PROTECTION_SCHEME_SELECT ? locks[blk] : bp_hit;
  wire            chip_ref = ~PROTECTION_SCHEME_SELECT & (BLOCK_PROTECT_BITS != 4'h0);

  wire addr_ok  = is_addr & (cnt_r == need) & ~prot_hit;
  wire chip_ok  = is_chip & op_only & ~chip_ref;
  wire go       = cs_rise & ~busy_r & wel_r & (addr_ok | chip_ok);
  wire write_enable_cmd_ok  = cs_rise & ~busy_r & op_only & (op_r == WRITE_ENABLE_CMD);
  wire en4_ok   = cs_rise & ~busy_r & op_only & (op_r == FOUR_BYTE_MODE_ENTRY_CMD);
  wire ex4_ok   = cs_rise & ~busy_r & op_only & (op_r == FOUR_BYTE_MODE_EXIT_CMD);

  wire sfe_kind_t kind_w = is_sector ? KIND_SECTOR : is_half ? KIND_HALF : is_block ? KIND_BLOCK : KIND_CHIP;
  wire [31:0] base_w  = is_sector ? (addr_full & SECTOR_MASK) :
                        is_half   ? (addr_full & HALF_MASK) :
                        is_block  ? (addr_full & BLOCK_MASK) :
                        32'h0;
  wire [NBLK-1:0] skip_w = (is_chip & PROTECTION_SCHEME_SELECT) ? locks : '0;
  wire [31:0] cyc_w   = is_sector ? 32'(SE_CYC - 1) :
                        is_half   ? 32'(HBE_CYC - 1) :
                        is_block  ? 32'(BE_CYC - 1) : 32'(CE_CYC - 1);
  wire done_w = busy_r & (tmr_r == 32'h0);

  // Status byte answers at any time, also in the middle of an erase
  wire [7:0] stat    = {6'h00, wel_r, busy_r};
  wire       rd_ph   = sel & (op_r == READ_STATUS_CMD) & (cnt_r >= LEN_OP);
  wire [2:0] idx     = 3'(cnt_r - LEN_OP);
  wire [3:0] dout_nx = QUAD_COMMAND_MODE ? (idx[2] ? stat[3:0] : stat[7:4]) : {2'h0, stat[3'h7 - idx], 1'b0};

  assign LINK.d_sio_o  = dout_r;
  assign LINK.d_sio_oe = rd_ph ? (QUAD_COMMAND_MODE ? 4'hF : 4'h2) : 4'h0;
  assign BUSY_FLAG          = busy_r;
  assign WRITE_ENABLE_LATCH = wel_r;
  assign FOUR_BYTE_MODE     = addr4_r;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sclk_q_r <= 1'b0;
      cs_q_r   <= 1'b1;
      cnt_r    <= 7'd0;
      op_r     <= 8'h00;
      addr_r   <= 32'h0;
      dout_r   <= 4'h0;
    end else begin
      sclk_q_r <= LINK.sclk;
      cs_q_r   <= LINK.cs_n;
      if (!sel) begin
        cnt_r <= 7'd0;
      end else if (sclk_rise) begin
        cnt_r <= cnt_nxt;
        if (cnt_r < LEN_OP) op_r <= op_nxt;
        else addr_r <= addr_nxt;
      end
      if (rd_ph && sclk_fall) dout_r <= dout_nx;
    end
  end

  // Latch clears only at the end of a cycle, when a new write enable is refused anyway
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_r  <= 1'b0;
      wel_r   <= 1'b0;
      addr4_r <= 1'b0;
      tmr_r   <= 32'h0;
    end else begin
      if (write_enable_cmd_ok) wel_r <= 1'b1;
      if (en4_ok) addr4_r <= 1'b1;
      if (ex4_ok) addr4_r <= 1'b0;
      if (go) begin
        busy_r <= 1'b1;
        tmr_r  <= cyc_w;
      end else if (done_w) begin
        busy_r <= 1'b0;
        wel_r  <= 1'b0;
      end else if (busy_r) begin
        tmr_r <= tmr_r - 32'h1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ERASE_GO   <= 1'b0;
      ERASE_KIND <= KIND_SECTOR;
      ERASE_BASE <= 32'h0;
      ERASE_SKIP <= '0;
      ERASE_DONE <= 1'b0;
    end else begin
      ERASE_GO   <= go;
      ERASE_DONE <= done_w;
      if (go) begin
        ERASE_KIND <= kind_w;
        ERASE_BASE <= base_w;
        ERASE_SKIP <= skip_w;
      end
    end
  end
endmodule : sfe_flash_end

/* verification/sfe_erase_monitor.sv */
`timescale 1ns/1ns
module sfe_erase_monitor
  import sfe_pkg::*;
#(
  parameter int SE_CYC  = 5000,
  parameter int HBE_CYC = 10000,
  parameter int BE_CYC  = 20000,
  parameter int CE_CYC  = 80000
) (
  input wire logic      CLK,
  input wire logic      RESET_N,
  input wire logic      cs_n,
  input wire logic      sclk,
  input wire logic      ERASE_GO,
  input wire sfe_kind_t ERASE_KIND,
  input wire logic      ERASE_DONE,
  input wire logic      BUSY_FLAG,
  input wire logic      WRITE_ENABLE_LATCH
);
  int busy_len_r;
  int want_len;
  assign want_len = (ERASE_KIND == KIND_SECTOR) ? SE_CYC : (ERASE_KIND == KIND_HALF) ? HBE_CYC :
                    (ERASE_KIND == KIND_BLOCK) ? BE_CYC : CE_CYC;
  // Busy length of the running erase, restarted at each go
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) busy_len_r <= 0;
    else if (ERASE_GO) busy_len_r <= 1; // Go cycle already shows busy
    else if (BUSY_FLAG) busy_len_r <= busy_len_r + 1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence finish_seq;
    ERASE_DONE ##1 (!BUSY_FLAG && !WRITE_ENABLE_LATCH);
  endsequence
  a_go_after_cs: assert property (ERASE_GO |-> cs_n && (!$past(cs_n, 2) || !$past(cs_n, 3) || !$past(cs_n, 4)))
    else $error("erase started without a chip select rise");
  a_busy_after_go: assert property (ERASE_GO |=> BUSY_FLAG)
    else $error("busy not set after erase start");
  a_go_needs_wel: assert property (ERASE_GO |-> WRITE_ENABLE_LATCH)
    else $error("erase started with write enable clear");
  a_go_when_idle: assert property (ERASE_GO |-> !$past(BUSY_FLAG))
    else $error("erase started while busy");
  a_done_clears_flags: assert property (ERASE_DONE |-> finish_seq)
    else $error("completion left busy or write enable set");
  a_erase_length: assert property ($fell(BUSY_FLAG) |-> busy_len_r >= want_len && busy_len_r <= want_len + 1)
    else $error("erase busy time wrong");
  a_wel_while_busy: assert property (BUSY_FLAG |-> WRITE_ENABLE_LATCH)
    else $error("write enable dropped during erase");
  a_done_ends_busy: assert property (ERASE_DONE |-> $past(BUSY_FLAG))
    else $error("done without busy");
  a_cs_sclk_low: assert property ($changed(cs_n) |-> !sclk)
    else $error("chip select moved with clock high");
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside frame");
  c_chip_go: cover property (ERASE_GO && ERASE_KIND == KIND_CHIP);
endmodule : sfe_erase_monitor

/* verification/serial_flash_erase_commands_bench.sv */
`timescale 1ns/1ns
module serial_flash_erase_commands_bench;
  import sfe_pkg::*;
  localparam int SE = 200, HBE = 220, BE = 240, CE = 300;
  logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready, quad, pss, extended_address_bit;
  logic awready, wready, bvalid, arready, rvalid, irq, go, done, busy, write_enable_latch, fourb;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, base, base_c, rv;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] bp;
  logic [15:0] plock, dlock, skip, skip_c;
  sfe_kind_t kind, kind_c;
  int go_cnt, miscompares, checks_done;
  sfe_link_if i_sfe_link_if ();
  sfe_host_end i_sfe_host_end (.LINK(i_sfe_link_if), .CLK(clk), .RESET_N(reset_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .IRQ(irq));
  sfe_flash_end #(.SE_CYC(SE), .HBE_CYC(HBE), .BE_CYC(BE), .CE_CYC(CE)) i_sfe_flash_end (.LINK(i_sfe_link_if),
    .CLK(clk), .RESET_N(reset_n), .PROTECTION_SCHEME_SELECT(pss), .BLOCK_PROTECT_BITS(bp),
    .PERSISTENT_SECTOR_LOCK(plock), .DYNAMIC_SECTOR_LOCK(dlock), .QUAD_COMMAND_MODE(quad),
    .EXTENDED_ADDRESS_BIT(extended_address_bit), .ERASE_GO(go), .ERASE_KIND(kind), .ERASE_BASE(base), .ERASE_SKIP(skip),
    .ERASE_DONE(done), .BUSY_FLAG(busy), .WRITE_ENABLE_LATCH(write_enable_latch), .FOUR_BYTE_MODE(fourb));
  sfe_erase_monitor #(.SE_CYC(SE), .HBE_CYC(HBE), .BE_CYC(BE), .CE_CYC(CE)) i_sfe_erase_monitor (.CLK(clk),
    .RESET_N(reset_n), .cs_n(i_sfe_link_if.cs_n), .sclk(i_sfe_link_if.sclk), .ERASE_GO(go), .ERASE_KIND(kind),
    .ERASE_DONE(done), .BUSY_FLAG(busy), .WRITE_ENABLE_LATCH(write_enable_latch));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Snapshot of each erase start
  always @(posedge clk) begin
    if (go === 1'b1) begin
      go_cnt++;
      kind_c = kind;
      base_c = base;
      skip_c = skip;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic timed_out;
    check(32'h0, 32'h1);
    tally_and_finish;
  endtask : timed_out
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    resp = bresp;
    bready <= 1'b0;
    if (n >= 100) timed_out;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 100) timed_out;
  endtask : axi_rd
  // One link frame; returns once the engine is idle and the device has seen chip select rise
  task automatic frame(input logic [7:0] op, input logic [2:0] na, input logic [31:0] a, input logic rd);
    int n;
    axi_wr(REG_ADDR, a);
    axi_wr(REG_CMD, {19'h0, rd, quad, na, op});
    n = 0;
    do begin
      axi_rd(REG_STAT, rv);
      n++;
    end while (rv[0] !== 1'b0 && n < 300);
    if (n >= 300) timed_out;
    repeat (4) @(posedge clk);
  endtask : frame
  task automatic status_rd;
    frame(READ_STATUS_CMD, 3'h0, 32'h0, 1'b1);
    axi_rd(REG_RXD, rv);
  endtask : status_rd
  task automatic erase(input logic we, input logic [7:0] op, input logic [2:0] na, input logic [31:0] a,
                       input logic g, input sfe_kind_t k, input logic [31:0] b);
    int c, n;
    if (we) frame(WRITE_ENABLE_CMD, 3'h0, 32'h0, 1'b0);
    c = go_cnt;
    frame(op, na, a, 1'b0);
    check(32'(go_cnt - c), {31'h0, g});
    if (g) begin
      check({30'h0, kind_c}, {30'h0, k});
      check(base_c, b);
      status_rd;
      check(rv, 32'h3);
      n = 0;
      do begin
        status_rd;
        n++;
      end while (rv[0] !== 1'b0 && n < 50);
      if (n >= 50) timed_out;
      check(rv, 32'h0);
    end else begin
      status_rd;
      check(rv, {30'h0, we, 1'b0});
    end
  endtask : erase
  initial begin
    reset_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; quad = 1'b0; pss = 1'b0; extended_address_bit = 1'b0;
    bp = 4'h0; plock = 16'h0; dlock = 16'h0;
    go_cnt = 0; miscompares = 0; checks_done = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    axi_wr(REG_IMASK, 32'h1);
    erase(1'b0, SECTOR_ERASE_CMD, 3'h3, 32'h00123ABC, 1'b0, KIND_SECTOR, 32'h0);
    check({31'h0, irq}, 32'h1);
    axi_rd(REG_ISTAT, rv);
    check(rv, 32'h1);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    axi_wr(REG_IMASK, 32'h0);
    status_rd;
    check({31'h0, irq}, 32'h0);
    axi_rd(8'h40, rv);
    check({rv[31:2], resp}, {30'h0, RESP_SLVERR});
    axi_wr(8'h40, 32'h0);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_rd(REG_ISTAT, rv);
    // Second command lands while the first frame still runs
    axi_wr(REG_CMD, {24'h0, READ_STATUS_CMD});
    axi_wr(REG_CMD, {24'h0, READ_STATUS_CMD});
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    repeat (60) @(posedge clk);
    axi_rd(REG_ISTAT, rv);
    check(rv, 32'h3);
    erase(1'b1, SECTOR_ERASE_CMD, 3'h3, 32'h00123ABC, 1'b1, KIND_SECTOR, 32'h00123000);
    erase(1'b1, SECTOR_ERASE_CMD, 3'h2, 32'h00123ABC, 1'b0, KIND_SECTOR, 32'h0);
    quad <= 1'b1;
    erase(1'b1, HALF_BLOCK_ERASE_CMD, 3'h3, 32'h00ABCDEF, 1'b1, KIND_HALF, 32'h00AB8000);
    erase(1'b1, CHIP_ERASE_CMD, 3'h0, 32'h0, 1'b1, KIND_CHIP, 32'h0);
    check({16'h0, skip_c}, 32'h0);
    quad <= 1'b0;
    extended_address_bit <= 1'b1;
    erase(1'b1, BLOCK_ERASE_CMD, 3'h3, 32'h00AB1234, 1'b1, KIND_BLOCK, 32'h01AB0000);
    extended_address_bit <= 1'b0;
    frame(FOUR_BYTE_MODE_ENTRY_CMD, 3'h0, 32'h0, 1'b0);
    check({31'h0, fourb}, 32'h1);
    erase(1'b1, BLOCK_ERASE_CMD, 3'h3, 32'h00AB1234, 1'b0, KIND_BLOCK, 32'h0);
    erase(1'b1, SECTOR_ERASE_CMD, 3'h4, 32'h02345678, 1'b1, KIND_SECTOR, 32'h02345000);
    frame(FOUR_BYTE_MODE_EXIT_CMD, 3'h0, 32'h0, 1'b0);
    check({31'h0, fourb}, 32'h0);
    erase(1'b1, CHIP_ERASE_CMD, 3'h1, 32'h0, 1'b0, KIND_CHIP, 32'h0);
    bp <= 4'h1;
    erase(1'b1, SECTOR_ERASE_CMD, 3'h3, 32'h000F1000, 1'b0, KIND_SECTOR, 32'h0);
    erase(1'b1, BLOCK_ERASE_CMD, 3'h3, 32'h00010000, 1'b1, KIND_BLOCK, 32'h00010000);
    erase(1'b1, CHIP_ERASE_CMD, 3'h0, 32'h0, 1'b0, KIND_CHIP, 32'h0);
    bp <= 4'h0; pss <= 1'b1; dlock <= 16'h0004; plock <= 16'h8000;
    erase(1'b1, SECTOR_ERASE_CMD, 3'h3, 32'h00020000, 1'b0, KIND_SECTOR, 32'h0);
    erase(1'b1, CHIP_ERASE_CMD, 3'h0, 32'h0, 1'b1, KIND_CHIP, 32'h0);
    check({16'h0, skip_c}, 32'h00008004);
    tally_and_finish;
  end
endmodule : serial_flash_erase_commands_bench
